/* verilog/pcrc_pkg.sv */
// Package for the programmable CRC generator: widths, fields, reset values, types
package pcrc_pkg;
  localparam int PCRC_MAX_ORDER = 32;
  localparam int PCRC_LEN_W = 5;
  localparam int PCRC_HALF_W = 16;
  localparam int PCRC_LEN_LSB = 0;
  localparam int PCRC_LEN_MSB = 4;
  localparam logic [PCRC_MAX_ORDER-1:0] PCRC_CRC_RESET = 32'h0000_0000;
  localparam logic [PCRC_LEN_W-1:0] PCRC_LEN_RESET = 5'h00;
  localparam logic [PCRC_HALF_W-1:0] PCRC_TERMS_RESET = 16'h0000;
  localparam logic [PCRC_MAX_ORDER-1:0] PCRC_ONE = 32'h0000_0001;

  typedef logic [PCRC_MAX_ORDER-1:0] pcrc_word_t;

  // Configuration as software presents it
  typedef struct packed {
    logic [PCRC_HALF_W-1:0] configRegB;
    logic [PCRC_HALF_W-1:0] polyTermsHigh;
    logic [PCRC_HALF_W-1:0] polyTermsLow;
  } pcrc_cfg_s;

  typedef enum logic [1:0] {
    PCRC_IDLE = 2'b00,
    PCRC_RUN = 2'b01
  } pcrc_state_e;
endpackage : pcrc_pkg

/* verilog/pcrc_step.sv */
// One LFSR step of the CRC engine for a given tap mask and length
`timescale 1ns/10ps
module pcrc_step
  import pcrc_pkg::*;
(
  input wire pcrc_word_t crcIn,
  input wire logic dataBit,
  input wire pcrc_word_t tapMask,
  input wire pcrc_word_t lenMask,
  input wire logic [PCRC_LEN_W-1:0] polyLengthField,
  output pcrc_word_t crcOut
);
  logic feedback;
  pcrc_word_t shifted;

  always_comb begin
    // Top used bit is order-1 = polyLengthField
    feedback = crcIn[polyLengthField] ^ dataBit; // [R06] [R07]
    shifted = {crcIn[PCRC_MAX_ORDER-2:0], 1'b0};
    crcOut = (shifted ^ (feedback ? tapMask : '0)) & lenMask; // [R04] [R09]
  end
endmodule : pcrc_step

/* verilog/pcrc_top.sv */
// Programmable CRC generator top: configuration capture, engine, result register
// How it works
// R01: Any order from small values up to 32 is handled in one 32-bit feedback register.
// R02: The highest exponent comes from the five-bit length field in bits 4..0 of config register B.
// R03: Term selection is split into a low half for exponents 15..0 and a high half for 31..16.
// R04: A set term bit puts an XOR tap at that position and a clear bit puts none.
// R05: The constant term is always tapped and stored term bit zero is ignored.
// R06: The exponent-N term is taken as present for length N whatever the term bits hold.
// R07: There is no term bit for exponent 32, so an order-32 polynomial uses only the implied top term.
// R08: The length field encodes order minus one, so 01111 is sixteen bits and 11111 is thirty-two.
// R09: Each shifted-in data bit updates the register as an LFSR over bits below the order and is readable.
`timescale 1ns/10ps
module pcrc_top
  import pcrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire pcrc_cfg_s cfgIn,
  input wire logic cfgLoad,
  input wire logic seedLoad,
  input wire pcrc_word_t seedValue,
  input wire logic dataValid,
  input wire logic dataBit,
  output pcrc_word_t crcResult,
  output logic [PCRC_LEN_W-1:0] polyLengthField,
  output logic busy
);
  // Bit mask of positions below order = len+1
  function automatic pcrc_word_t lenToMask(input logic [PCRC_LEN_W-1:0] len);
    pcrc_word_t m;
    m = '0;
    for (int i = 0; i < PCRC_MAX_ORDER; i++) begin
      if (i <= int'(len)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : lenToMask

  logic [PCRC_LEN_W-1:0] polyLength_r;
  logic [PCRC_HALF_W-1:0] polyTermsLow_r;
  logic [PCRC_HALF_W-1:0] polyTermsHigh_r;
  pcrc_word_t crc_r;
  pcrc_word_t crc_nxt;
  pcrc_word_t tapMask;
  pcrc_word_t termBits;
  pcrc_word_t lenMask;
  pcrc_state_e state_r;

  // Configuration capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polyLength_r <= PCRC_LEN_RESET;
      polyTermsLow_r <= PCRC_TERMS_RESET;
      polyTermsHigh_r <= PCRC_TERMS_RESET;
    end else if (cfgLoad) begin
      polyLength_r <= cfgIn.configRegB[PCRC_LEN_MSB:PCRC_LEN_LSB]; // [R02] [R08]
      polyTermsLow_r <= cfgIn.polyTermsLow; // [R03]
      polyTermsHigh_r <= cfgIn.polyTermsHigh; // [R03]
    end
  end

  // Taps sit at exponents 0..len, bit 0 always; the implied top term (exponent len+1) is the
  // feedback itself, so no term-32 bit is ever needed.
  always_comb begin
    termBits = {polyTermsHigh_r, polyTermsLow_r}; // [R03]
    lenMask = lenToMask(polyLength_r); // [R01]
    tapMask = (termBits & ~PCRC_ONE) | PCRC_ONE; // [R03] [R04] [R05] [R07]
    tapMask = tapMask & lenMask; // [R06]
  end

  pcrc_step u_step (
    .crcIn(crc_r),
    .dataBit(dataBit),
    .tapMask(tapMask),
    .lenMask(lenMask),
    .polyLengthField(polyLength_r),
    .crcOut(crc_nxt)
  );

  // Shift register; seed wins over data in the same cycle
  // Idle cycles trim bits that a shorter order no longer uses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crc_r <= PCRC_CRC_RESET;
    end else if (seedLoad) begin
      crc_r <= seedValue & lenMask;
    end else if (dataValid) begin
      crc_r <= crc_nxt; // [R09]
    end else begin
      crc_r <= crc_r & lenMask; // [R09]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= PCRC_IDLE;
    end else begin
      state_r <= dataValid ? PCRC_RUN : PCRC_IDLE;
    end
  end

  // Outputs straight from flip-flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      crcResult <= PCRC_CRC_RESET;
      polyLengthField <= PCRC_LEN_RESET;
      busy <= 1'b0;
    end else begin
      crcResult <= crc_r; // [R09]
      polyLengthField <= polyLength_r;
      busy <= (state_r == PCRC_RUN);
    end
  end

  // Engine stepping
  AST_SHIFT: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    (dataValid && !seedLoad) |=> (crc_r == $past(crc_nxt)))
    else $error("CRC register did not take the LFSR step");

  // Independent of the tap mask: without feedback the step is a plain shift
  AST_NO_FEEDBACK: assert property (@(posedge sys_clk) disable iff (rst) // [R04]
    (dataValid && !seedLoad && !(crc_r[polyLength_r] ^ dataBit)) |=>
      (crc_r == (($past(crc_r) << 1) & $past(lenMask))))
    else $error("Step without feedback is not a plain shift");

  AST_TOP_TERM: assert property (@(posedge sys_clk) disable iff (rst) // [R06]
    (dataValid && !seedLoad && (crc_r[polyLength_r] ^ dataBit)) |=> (crc_r[0] == 1'b1))
    else $error("Implied top term did not feed back");

  // No term bit exists for exponent 32, so the feedback must come from bit 31
  AST_ORDER32_TOP: assert property (@(posedge sys_clk) disable iff (rst) // [R07]
    ((polyLength_r == 5'h1f) && dataValid && !seedLoad) |=>
      (crc_r[0] == $past(crc_r[PCRC_MAX_ORDER-1] ^ dataBit)))
    else $error("Order 32 feedback not taken from the top bit");

  // Seed wins over a data bit in the same cycle
  AST_SEED: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    seedLoad |=> (crc_r == ($past(seedValue) & $past(lenMask))))
    else $error("Seed not loaded within the order");

  // Idle cycles also trim bits left over from a longer order
  AST_CRC_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    (!seedLoad && !dataValid) |=> (crc_r == ($past(crc_r) & $past(lenMask))))
    else $error("CRC register moved while idle");

  AST_HIGH_BITS_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [R01]
    ((crc_r & ~lenMask) == '0) || $past(cfgLoad))
    else $error("CRC bits above the order are set");

  AST_RESULT: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    ##1 (crcResult == $past(crc_r)))
    else $error("Result does not follow the engine");

  // Busy flag timing
  AST_STATE: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    1'b1 |=> ((state_r == PCRC_RUN) == $past(dataValid)))
    else $error("Run state does not follow data valid");

  AST_BUSY: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    1'b1 |=> ##1 (busy == $past(dataValid, 2)))
    else $error("Busy is not data valid two cycles late");

  // Configuration capture
  AST_LEN_CAPTURE: assert property (@(posedge sys_clk) disable iff (rst) // [R02]
    cfgLoad |=> (polyLength_r == $past(cfgIn.configRegB[PCRC_LEN_MSB:PCRC_LEN_LSB])))
    else $error("Length field not captured from bits 4..0");

  AST_TERMS_CAPTURE: assert property (@(posedge sys_clk) disable iff (rst) // [R03]
    cfgLoad |=> ((polyTermsHigh_r == $past(cfgIn.polyTermsHigh)) &&
      (polyTermsLow_r == $past(cfgIn.polyTermsLow))))
    else $error("Term halves not captured");

  AST_CFG_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R02]
    !cfgLoad |=> ($stable(polyLength_r) && $stable(polyTermsLow_r) && $stable(polyTermsHigh_r)))
    else $error("Configuration changed without a load");

  AST_LEN_OUT: assert property (@(posedge sys_clk) disable iff (rst) // [R02]
    1'b1 |=> (polyLengthField == $past(polyLength_r)))
    else $error("Length output does not follow the captured field");

  // Tap and order masks
  AST_CONST_TAP: assert property (@(posedge sys_clk) disable iff (rst) // [R05]
    tapMask[0] == 1'b1)
    else $error("Constant term tap missing");

  AST_TAP_SELECT: assert property (@(posedge sys_clk) disable iff (rst) // [R04]
    (tapMask[PCRC_MAX_ORDER-1:1] == (termBits[PCRC_MAX_ORDER-1:1] & lenMask[PCRC_MAX_ORDER-1:1])))
    else $error("Tap positions differ from term bits");

  AST_TAPS_ABOVE: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
    ((tapMask & ~lenMask) == '0))
    else $error("Tap set above the order");

  AST_ORDER_MIN: assert property (@(posedge sys_clk) disable iff (rst) // [R01]
    (polyLength_r == PCRC_LEN_RESET) |-> (lenMask == PCRC_ONE))
    else $error("Length zero is not order one");

  AST_ORDER16: assert property (@(posedge sys_clk) disable iff (rst) // [R08]
    (polyLength_r == 5'h0f) |-> (lenMask == 32'h0000_ffff))
    else $error("Length 01111 is not sixteen bits");

  AST_ORDER32: assert property (@(posedge sys_clk) disable iff (rst) // [R07]
    (polyLength_r == 5'h1f) |-> (lenMask == 32'hffff_ffff))
    else $error("Length 11111 is not thirty-two bits");

  // One check per bit position keeps a wrong tap or mask bit easy to locate
  for (genvar g = 1; g < PCRC_MAX_ORDER; g++) begin : g_tapBit
    AST_TAP_BIT: assert property (@(posedge sys_clk) disable iff (rst) // [R04]
      tapMask[g] == (termBits[g] && (g <= int'(polyLength_r))))
      else $error("Tap bit does not follow its term bit");
  end

  for (genvar g = 0; g < PCRC_MAX_ORDER; g++) begin : g_lenBit
    AST_LEN_BIT: assert property (@(posedge sys_clk) disable iff (rst) // [R08]
      lenMask[g] == (g <= int'(polyLength_r)))
      else $error("Order mask bit wrong for the length field");
  end

  COV_ORDER16: cover property (@(posedge sys_clk) disable iff (rst) (polyLength_r == 5'h0f) && dataValid);
  COV_ORDER32: cover property (@(posedge sys_clk) disable iff (rst) (polyLength_r == 5'h1f) && dataValid);
  COV_SEED: cover property (@(posedge sys_clk) disable iff (rst) seedLoad ##1 dataValid[*4]);
  COV_FEEDBACK: cover property (@(posedge sys_clk) disable iff (rst)
    dataValid && !seedLoad && (crc_r[polyLength_r] ^ dataBit));
  COV_SHRINK: cover property (@(posedge sys_clk) disable iff (rst)
    cfgLoad && (cfgIn.configRegB[PCRC_LEN_MSB:PCRC_LEN_LSB] < polyLength_r));
endmodule : pcrc_top

/* sim/programmable_crc_generator_tb.sv */
// Self-checking testbench for the programmable CRC generator
`timescale 1ns/10ps
module programmable_crc_generator_tb;
  import pcrc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cfgLoad = 1'b0;
  logic seedLoad = 1'b0;
  logic dataValid = 1'b0;
  logic dataBit = 1'b0;
  pcrc_cfg_s cfgIn = '0;
  pcrc_word_t seedValue = '0;
  pcrc_word_t crcResult;
  logic [PCRC_LEN_W-1:0] polyLengthField;
  logic busy;
  int failures = 0;
  int compares = 0;
  always #50 sys_clk = ~sys_clk;
  pcrc_top dut (.sys_clk(sys_clk), .rst(rst), .cfgIn(cfgIn), .cfgLoad(cfgLoad), .seedLoad(seedLoad),
    .seedValue(seedValue), .dataValid(dataValid), .dataBit(dataBit), .crcResult(crcResult),
    .polyLengthField(polyLengthField), .busy(busy));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic check_word(input pcrc_word_t got, input pcrc_word_t exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Shared run: upper config bits set on purpose, they must be ignored
  task automatic run_crc(input logic [4:0] len, input logic [15:0] hi, input logic [15:0] lo,
      input pcrc_word_t seed, input pcrc_word_t msg);
    pcrc_word_t mask;
    pcrc_word_t taps;
    pcrc_word_t model;
    logic fb;
    mask = (len == 5'h1f) ? 32'hffff_ffff : (PCRC_ONE << (len + 1)) - 32'h0000_0001;
    taps = ({hi, lo} | PCRC_ONE) & mask;
    cfgIn = '{configRegB: {11'h5a5, len}, polyTermsHigh: hi, polyTermsLow: lo};
    cfgLoad = 1'b1;
    tick(1);
    cfgLoad = 1'b0;
    tick(1);
    check_word({27'h0, polyLengthField}, {27'h0, len});
    seedValue = seed;
    seedLoad = 1'b1;
    tick(1);
    seedLoad = 1'b0;
    model = seed & mask;
    for (int i = 31; i >= 0; i--) begin
      dataValid = 1'b1;
      dataBit = msg[i];
      tick(1);
      fb = model[len] ^ msg[i];
      model = ((model << 1) ^ (fb ? taps : 32'h0000_0000)) & mask;
      if (i == 16) check_word({31'h0, busy}, PCRC_ONE);
    end
    dataValid = 1'b0;
    tick(2);
    check_word(crcResult, model);
    check_word({31'h0, busy}, 32'h0000_0000);
    $display("test done len %h", len);
  endtask : run_crc
  // Bit zero of the low half left clear: constant term still tapped
  task automatic test_crc16();
    run_crc(5'h0f, 16'h0000, 16'h1020, 32'h0000_ffff, 32'h3132_3334);
  endtask : test_crc16
  task automatic test_crc32();
    run_crc(5'h1f, 16'h04c1, 16'h1db6, 32'hffff_ffff, 32'hdead_beef);
  endtask : test_crc32
  // Order four with every term bit above the order set: those must not leak
  task automatic test_small();
    run_crc(5'h03, 16'hffff, 16'hfff2, 32'hffff_fff5, 32'h8c3a_5e71);
  endtask : test_small
  initial begin
    tick(5);
    rst = 1'b0;
    check_word(crcResult, PCRC_CRC_RESET);
    test_crc16();
    test_crc32();
    test_small();
    test_crc16();
    end_sim();
  end
endmodule : programmable_crc_generator_tb
